//--- include/cmp_pkg.sv
// shared constants and types for the dual comparator control block
// assumes a 20 MHz core clock and a 32-bit AXI4-Lite register bus
package cmp_pkg;
  localparam int          ADDR_W        = 4;
  localparam logic [3:0]  CMP1_CTRL_OFS = 4'h0;
  localparam logic [3:0]  CMP2_CTRL_OFS = 4'h4;
  localparam logic [3:0]  FLAG_OFS      = 4'h8;
  localparam logic [3:0]  IRQ_EN_OFS    = 4'hc;
  localparam logic [3:0]  WORD_MASK     = 4'hc;

  // control register field positions
  localparam int ENABLE_BIT = 7;
  localparam int RESULT_BIT = 6;
  localparam int DRIVE_BIT  = 5;
  localparam int INVERT_BIT = 4;
  localparam int UNUSED_BIT = 3;
  localparam int REF_BIT    = 2;
  localparam int CHAN_MSB   = 1;
  localparam int CHAN_LSB   = 0;

  // interrupt enable register field positions (bits 1:0 are per-comparator enables)
  localparam int PERIPH_EN_BIT = 6;
  localparam int GLOBAL_EN_BIT = 7;

  localparam logic [1:0] FLAG_RESET  = 2'h0;
  localparam logic [1:0] IE_RESET    = 2'h0;
  localparam logic [1:0] LAST_PHASE  = 2'h3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // software must wait this long after enabling before trusting the change flag
  localparam int CLK_MHZ            = 20;
  localparam int BIAS_SETTLE_US     = 1;
  localparam int BIAS_SETTLE_CYCLES = BIAS_SETTLE_US * CLK_MHZ;

  typedef struct packed {
    logic       enable;
    logic       drive_enable;
    logic       invert;
    logic       ref_select;
    logic [1:0] channel_select;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '0;
endpackage : cmp_pkg

//--- include/cmp_chan_if.sv
// control and status between the register block and one comparator channel
// assumes both ends run on core_clk
`timescale 1ns/1ns
interface cmp_chan_if;
  logic enable;
  logic invert;
  logic read_strobe;
  logic result;
  logic live;
  logic change_pulse;

  modport ctrl (output enable, output invert, output read_strobe,
                input result, input live, input change_pulse);
  modport chan (input enable, input invert, input read_strobe,
                output result, output live, output change_pulse);
endinterface : cmp_chan_if

//--- src/q_phase_divider.sv
// four-phase divider: one first-phase pulse per instruction cycle
// assumes core_clk is the only clock
`timescale 1ns/1ns
module q_phase_divider (
  input  wire logic core_clk,
  input  wire logic rst,
  output logic      q1_tick
);
  typedef struct packed {
    logic [1:0] count;
    logic       tick;
  } div_state_t;

  div_state_t state;
  div_state_t next_state;

  always_comb begin
    next_state       = state;
    next_state.count = 2'(state.count + 2'h1);
    next_state.tick  = (state.count == cmp_pkg::LAST_PHASE);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign q1_tick = state.tick;
endmodule : q_phase_divider

//--- src/comparator_channel.sv
// one comparator channel: input synchroniser, polarity, mismatch latches
// assumes raw_compare is asynchronous and q1_tick is one cycle in four
`timescale 1ns/1ns
module comparator_channel (
  input  wire logic  core_clk,
  input  wire logic  rst,
  input  wire logic  q1_tick,
  input  wire logic  raw_compare,
  cmp_chan_if.chan   link
);
  typedef struct packed {
    logic sync_first;
    logic sync_second;
    logic sample_latch;
    logic read_latch;
    logic mismatch_seen;
    logic change_pulse;
    logic live;
  } chan_state_t;

  chan_state_t state;
  chan_state_t next_state;
  logic        mismatch_now;

  always_comb begin
    next_state = state;
    next_state.sync_first  = raw_compare;
    next_state.sync_second = state.sync_first;
    next_state.live = link.enable & (state.sync_second ^ link.invert);
    if (q1_tick) begin
      next_state.sample_latch = link.enable & (state.sync_second ^ link.invert);
    end
    if (link.read_strobe) begin
      next_state.read_latch = state.sample_latch;
    end
    next_state.mismatch_seen = mismatch_now;
    next_state.change_pulse  = mismatch_now & ~state.mismatch_seen;
  end

  assign mismatch_now = state.sample_latch ^ state.read_latch;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign link.result       = state.sample_latch;
  assign link.live         = state.live;
  assign link.change_pulse = state.change_pulse;
endmodule : comparator_channel

//--- src/dual_comparator_control.sv
// dual comparator control and status with an AXI4-Lite register slave
// assumes the analog comparators, muxes and reference sit outside this block,
// and that port_direction_bit and sleep_mode come from logic on core_clk
//
// Overview of operation
// - top control bit enables comparator
// - result bit is read-only, polarity adjusted
// - invert bit flips comparison result
// - drive-enable bit routes result to pin
// - pin driven only if drive, enable, direction
// - reference bit selects internal reference input
// - two-bit field picks one of four pins
// - bit three always reads zero
// - second comparator mirrors the first
// - change during read may lose flag
// - enabled comparator keeps running in sleep
// - flagged change wakes with both enables
// - vector only after next instruction, global enable
// - reset clears both control registers
// - read latch versus first-phase latch mismatch
// - writes also clear the mismatch
// - flag set on mismatch rising edge
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
module dual_comparator_control (
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  // register bus
  input  wire logic [cmp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [cmp_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // analog side
  input  wire logic [1:0]                raw_compare,
  output logic [1:0]                     cmp_power_on,
  output logic [1:0]                     cmp_ref_select,
  output logic [3:0]                     cmp_channel_select,
  // pins and system
  input  wire logic [1:0]                port_direction_bit,
  output logic [1:0]                     cmp_pin_out,
  output logic [1:0]                     cmp_pin_oe,
  input  wire logic                      sleep_mode,
  output logic                           wake_request,
  output logic                           irq_request
);
  typedef struct packed {
    cmp_pkg::ctrl_t [1:0]         ctrl;
    logic [1:0]                   change_flag;
    logic [1:0]                   change_irq_enable;
    logic                         peripheral_irq_enable;
    logic                         global_irq_enable;
    logic                         aw_held;
    logic [cmp_pkg::ADDR_W-1:0]   aw_addr;
    logic                         w_held;
    logic [31:0]                  w_data;
    logic [3:0]                   w_strb;
    logic                         bvalid;
    logic [1:0]                   bresp;
    logic                         rvalid;
    logic [31:0]                  rdata;
    logic [1:0]                   rresp;
    logic [1:0]                   read_strobe;
    logic [1:0]                   pin_out;
    logic [1:0]                   pin_oe;
    logic                         wake_request;
    logic                         irq_request;
    logic                         was_asleep;
    logic                         defer_vector;
  } top_state_t;

  top_state_t state;
  top_state_t next_state;
  logic       q1_tick;
  logic [1:0] result;
  logic [1:0] live;
  logic [1:0] change_pulse;

  cmp_chan_if link [2] ();

  q_phase_divider u_phase (
    .core_clk (core_clk),
    .rst      (rst),
    .q1_tick  (q1_tick)
  );

  for (genvar i = 0; i < 2; i++) begin : g_chan
    comparator_channel u_chan (
      .core_clk    (core_clk),
      .rst         (rst),
      .q1_tick     (q1_tick),
      .raw_compare (raw_compare[i]),
      .link        (link[i])
    );
    assign link[i].enable      = state.ctrl[i].enable;
    assign link[i].invert      = state.ctrl[i].invert;
    assign link[i].read_strobe = state.read_strobe[i];
    assign result[i]           = link[i].result;
    assign live[i]             = link[i].live;
    assign change_pulse[i]     = link[i].change_pulse;
  end

  // control byte as software sees it; the result bit ignores writes
  function automatic logic [7:0] ctrl_byte(cmp_pkg::ctrl_t c, logic res);
    logic [7:0] b;
    b                       = 8'h00;
    b[cmp_pkg::ENABLE_BIT]  = c.enable;
    b[cmp_pkg::RESULT_BIT]  = res;
    b[cmp_pkg::DRIVE_BIT]   = c.drive_enable;
    b[cmp_pkg::INVERT_BIT]  = c.invert;
    b[cmp_pkg::UNUSED_BIT]  = 1'b0;
    b[cmp_pkg::REF_BIT]     = c.ref_select;
    b[cmp_pkg::CHAN_MSB:cmp_pkg::CHAN_LSB] = c.channel_select;
    return b;
  endfunction : ctrl_byte

  function automatic cmp_pkg::ctrl_t ctrl_from(logic [7:0] b);
    cmp_pkg::ctrl_t c;
    c.enable         = b[cmp_pkg::ENABLE_BIT];
    c.drive_enable   = b[cmp_pkg::DRIVE_BIT];
    c.invert         = b[cmp_pkg::INVERT_BIT];
    c.ref_select     = b[cmp_pkg::REF_BIT];
    c.channel_select = b[cmp_pkg::CHAN_MSB:cmp_pkg::CHAN_LSB];
    return c;
  endfunction : ctrl_from

  logic [cmp_pkg::ADDR_W-1:0] rd_word;
  logic [cmp_pkg::ADDR_W-1:0] wr_word;
  logic                       do_write;
  logic                       do_read;
  logic                       pending;
  logic                       sleep_exit;

  assign rd_word    = s_axi_araddr & cmp_pkg::WORD_MASK;
  assign wr_word    = state.aw_addr & cmp_pkg::WORD_MASK;
  assign do_write   = state.aw_held & state.w_held & ~state.bvalid;
  assign do_read    = s_axi_arvalid & ~state.rvalid;
  assign sleep_exit = state.was_asleep & ~sleep_mode;
  assign pending    = |(state.change_flag & state.change_irq_enable)
                      & state.peripheral_irq_enable;

  always_comb begin
    next_state             = state;
    next_state.read_strobe = 2'h0;

    // address and data are taken in either order and held until both are in
    if (s_axi_awvalid && !state.aw_held && !state.bvalid) begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state.w_held && !state.bvalid) begin
      next_state.w_held = 1'b1;
      next_state.w_data = s_axi_wdata;
      next_state.w_strb = s_axi_wstrb;
    end

    if (do_write) begin
      next_state.aw_held = 1'b0;
      next_state.w_held  = 1'b0;
      next_state.bvalid  = 1'b1;
      next_state.bresp   = cmp_pkg::RESP_OKAY;
      if (wr_word == cmp_pkg::CMP1_CTRL_OFS) begin
        if (state.w_strb[0]) begin
          next_state.ctrl[0] = ctrl_from(state.w_data[7:0]);
        end
        next_state.read_strobe[0] = 1'b1;
      end else if (wr_word == cmp_pkg::CMP2_CTRL_OFS) begin
        if (state.w_strb[0]) begin
          next_state.ctrl[1] = ctrl_from(state.w_data[7:0]);
        end
        next_state.read_strobe[1] = 1'b1;
      end else if (wr_word == cmp_pkg::FLAG_OFS) begin
        // writing a one raises the flag, as software may force an interrupt
        if (state.w_strb[0]) begin
          next_state.change_flag = state.w_data[1:0];
        end
      end else if (wr_word == cmp_pkg::IRQ_EN_OFS) begin
        if (state.w_strb[0]) begin
          next_state.change_irq_enable     = state.w_data[1:0];
          next_state.peripheral_irq_enable = state.w_data[cmp_pkg::PERIPH_EN_BIT];
          next_state.global_irq_enable     = state.w_data[cmp_pkg::GLOBAL_EN_BIT];
        end
      end else begin
        next_state.bresp = cmp_pkg::RESP_SLVERR;
      end
    end
    if (state.bvalid && s_axi_bready) begin
      next_state.bvalid = 1'b0;
    end

    if (do_read) begin
      next_state.rvalid = 1'b1;
      next_state.rresp  = cmp_pkg::RESP_OKAY;
      next_state.rdata  = 32'h0000_0000;
      if (rd_word == cmp_pkg::CMP1_CTRL_OFS) begin
        next_state.rdata[7:0]     = ctrl_byte(state.ctrl[0], result[0]);
        next_state.read_strobe[0] = 1'b1;
      end else if (rd_word == cmp_pkg::CMP2_CTRL_OFS) begin
        next_state.rdata[7:0]     = ctrl_byte(state.ctrl[1], result[1]);
        next_state.read_strobe[1] = 1'b1;
      end else if (rd_word == cmp_pkg::FLAG_OFS) begin
        next_state.rdata[1:0] = state.change_flag;
      end else if (rd_word == cmp_pkg::IRQ_EN_OFS) begin
        next_state.rdata[1:0]                   = state.change_irq_enable;
        next_state.rdata[cmp_pkg::PERIPH_EN_BIT] = state.peripheral_irq_enable;
        next_state.rdata[cmp_pkg::GLOBAL_EN_BIT] = state.global_irq_enable;
      end else begin
        next_state.rresp = cmp_pkg::RESP_SLVERR;
      end
    end else if (state.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
    end

    // set beats clear; a change still edges when the read latch catches it the next cycle
    next_state.change_flag = next_state.change_flag | change_pulse;

    for (int i = 0; i < 2; i++) begin
      next_state.pin_out[i] = live[i];
      next_state.pin_oe[i]  = state.ctrl[i].drive_enable & state.ctrl[i].enable
                              & ~port_direction_bit[i];
    end

    // channels never gated by sleep; wake request
    next_state.wake_request = pending;
    next_state.was_asleep   = sleep_mode;
    // hold the vector off after waking until the next first-phase tick
    if (sleep_exit) begin
      next_state.defer_vector = 1'b1;
    end else if (q1_tick) begin
      next_state.defer_vector = 1'b0;
    end
    next_state.irq_request = pending & state.global_irq_enable & ~sleep_mode
                             & ~sleep_exit & ~state.defer_vector;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign s_axi_awready = ~state.aw_held & ~state.bvalid;
  assign s_axi_wready  = ~state.w_held & ~state.bvalid;
  assign s_axi_bvalid  = state.bvalid;
  assign s_axi_bresp   = state.bresp;
  assign s_axi_arready = ~state.rvalid;
  assign s_axi_rvalid  = state.rvalid;
  assign s_axi_rdata   = state.rdata;
  assign s_axi_rresp   = state.rresp;

  // analog controls straight from the registers
  for (genvar j = 0; j < 2; j++) begin : g_analog
    assign cmp_power_on[j]             = state.ctrl[j].enable;
    assign cmp_ref_select[j]           = state.ctrl[j].ref_select;
    assign cmp_channel_select[2*j +: 2] = state.ctrl[j].channel_select;
  end

  assign cmp_pin_out  = state.pin_out;
  assign cmp_pin_oe   = state.pin_oe;
  assign wake_request = state.wake_request;
  assign irq_request  = state.irq_request;
endmodule : dual_comparator_control

//--- bench/dual_comparator_control_checker.sv
// port-level assertions for the dual comparator control block
// assumes it is bound into every dual_comparator_control instance
`timescale 1ns/1ns
module dual_comparator_control_checker (
  input wire logic                       core_clk,
  input wire logic                       rst,
  input wire logic [cmp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic [31:0]                s_axi_rdata,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_rready,
  input wire logic [1:0]                 s_axi_bresp,
  input wire logic                       s_axi_bvalid,
  input wire logic                       s_axi_bready,
  input wire logic [1:0]                 cmp_power_on,
  input wire logic [1:0]                 cmp_pin_out,
  input wire logic [1:0]                 cmp_pin_oe,
  input wire logic [1:0]                 port_direction_bit,
  input wire logic                       sleep_mode,
  input wire logic                       wake_request,
  input wire logic                       irq_request
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // address of the read in flight, so the answer can be judged per register
  logic [cmp_pkg::ADDR_W-1:0] rd_addr;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) rd_addr <= '0;
    else if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
  end

  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered in the next cycle");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped early");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped early");
  unused_zero_a: assert property (s_axi_rvalid && !rd_addr[3] |->
    !s_axi_rdata[3] && s_axi_rdata[31:8] == 24'h0) else $error("control read shows stray bits");
  off_pin_low_a: assert property (!cmp_power_on[0] [*3] |-> !cmp_pin_out[0])
    else $error("disabled comparator drives a result");
  dir_gates_oe_a: assert property (cmp_pin_oe[1] |-> !$past(port_direction_bit[1]))
    else $error("pin driven while direction is input");
  irq_needs_wake_a: assert property (irq_request |-> wake_request && !$past(sleep_mode))
    else $error("interrupt without wake term or while asleep");
  wake_defer_a: assert property ($fell(sleep_mode) |-> !irq_request ##1 !irq_request)
    else $error("interrupt not deferred after wake");
  // reset itself is the condition here, so no disable
  reset_clears_a: assert property (disable iff (1'b0) rst |->
    cmp_power_on == 2'h0 && cmp_pin_oe == 2'h0) else $error("reset left a comparator on");

  cover property (irq_request);
  cover property ($rose(wake_request));
  cover property (cmp_pin_oe[0]);
endmodule : dual_comparator_control_checker

bind dual_comparator_control dual_comparator_control_checker chk (
  .core_clk(core_clk), .rst(rst), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .cmp_power_on(cmp_power_on),
  .cmp_pin_out(cmp_pin_out), .cmp_pin_oe(cmp_pin_oe), .port_direction_bit(port_direction_bit),
  .sleep_mode(sleep_mode), .wake_request(wake_request), .irq_request(irq_request)
);

//--- bench/tb_dual_comparator_control.sv
// self-checking bench for the dual comparator control block
// assumes a 20 MHz core clock and the AXI4-Lite register map of cmp_pkg
`timescale 1ns/1ns
module tb_dual_comparator_control;
  logic        core_clk = 1'b0;
  logic        rst = 1'b0;
  logic [3:0]  awaddr = 4'h0;
  logic        awvalid = 1'b0;
  logic        awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic        wvalid = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready = 1'b0;
  logic [3:0]  araddr = 4'h0;
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready = 1'b0;
  logic [1:0]  raw = 2'h0;
  logic [1:0]  dir = 2'h0;
  logic        sleep = 1'b0;
  logic [1:0]  pwr, refs, pin, oe;
  logic [3:0]  chan;
  logic        wake, irq;
  logic [31:0] d;
  logic [1:0]  rr, br;
  int          fails = 0;
  int          samples_checked = 0;

  always #25 core_clk = ~core_clk;

  dual_comparator_control dut (
    .core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .raw_compare(raw), .cmp_power_on(pwr), .cmp_ref_select(refs), .cmp_channel_select(chan),
    .port_direction_bit(dir), .cmp_pin_out(pin), .cmp_pin_oe(oe), .sleep_mode(sleep),
    .wake_request(wake), .irq_request(irq)
  );

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // handshakes are judged on values settled before the edge that takes them
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    logic ah, wh, bh;
    int n;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge core_clk);
      ah = awvalid & awready;
      wh = wvalid & wready;
      bh = bvalid & bready;
      br = bresp;
      @(posedge core_clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) break;
    end
    bready <= 1'b0;
    check(32'(n < 40), 32'h1);
  endtask : wr

  task automatic rd(input logic [3:0] a);
    logic ah, rh;
    int n;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge core_clk);
      ah = arvalid & arready;
      rh = rvalid & rready;
      d = rdata;
      rr = rresp;
      @(posedge core_clk);
      if (ah) arvalid <= 1'b0;
      if (rh) break;
    end
    rready <= 1'b0;
    check(32'(n < 40), 32'h1);
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask : cyc

  task automatic t_fields();
    logic [7:0] v;
    for (int c = 0; c < 2; c++) begin
      for (int k = 0; k < 4; k++) begin
        // enable set, unused bit written high, reference and channel vary
        v = {5'h11, k[0], k[1:0]};
        wr(4'(4 * c), v);
        rd(4'(4 * c));
        check(d, {24'h0, v & 8'hf7});
        check(32'(chan[2*c +: 2]), 32'(k));
        check(32'(refs[c]), 32'(k[0]));
        check(32'(pwr[c]), 32'h1);
      end
      wstrb <= 4'h0;
      wr(4'(4 * c), 8'h00);
      wstrb <= 4'hf;
      cyc(1);
      check(32'(pwr[c]), 32'h1);
      wr(4'(4 * c), 8'h00);
      cyc(1);
      check(32'(pwr[c]), 32'h0);
    end
  endtask : t_fields

  task automatic t_polarity();
    logic e;
    for (int k = 0; k < 4; k++) begin
      e = k[0] ^ k[1];
      @(posedge core_clk);
      raw <= {2{k[0]}};
      wr(4'h0, {3'h4, k[1], 4'h0});
      wr(4'h4, {3'h4, k[1], 4'h0});
      cyc(12);
      check(32'(pin), 32'({e, e}));
      rd(4'h0);
      check(32'(d[6]), 32'(e));
      rd(4'h4);
      check(32'(d[6]), 32'(e));
    end
    wr(4'h0, 8'h40);
    cyc(3);
    check(32'(pin[0]), 32'h0);
    rd(4'h0);
    check(d, 32'h0);
  endtask : t_polarity

  task automatic t_drive();
    logic [2:0] s;
    for (int k = 0; k < 8; k++) begin
      s = 3'(k);
      @(posedge core_clk);
      dir <= {2{s[0]}};
      wr(4'h0, {s[1], 1'b0, s[2], 5'h0});
      wr(4'h4, {s[1], 1'b0, s[2], 5'h0});
      cyc(2);
      check(32'(oe), 32'({2{s[2] & s[1] & ~s[0]}}));
    end
  endtask : t_drive

  task automatic t_change();
    @(posedge core_clk);
    raw <= 2'h0;
    wr(4'hc, 8'h00);
    wr(4'h0, 8'h80);
    // bias settling after enabling, then clear mismatch and flags before the input rises
    cyc(cmp_pkg::BIAS_SETTLE_CYCLES);
    rd(4'h0);
    wr(4'h8, 8'h00);
    raw <= 2'h1;
    cyc(12);
    rd(4'h8);
    check(d, 32'h1);
    check(32'(wake), 32'h0);
    rd(4'h0);
    wr(4'h8, 8'h00);
    cyc(12);
    rd(4'h8);
    check(d, 32'h0);
    raw <= 2'h0;
    cyc(12);
    rd(4'h8);
    check(d, 32'h1);
    wr(4'h0, 8'h80);
    wr(4'h8, 8'h00);
    raw <= 2'h1;
    cyc(12);
    rd(4'h8);
    check(d, 32'h1);
  endtask : t_change

  task automatic t_wake();
    // comparator two is no wake source, so it sleeps powered down
    wr(4'h4, 8'h00);
    @(posedge core_clk);
    sleep <= 1'b1;
    wr(4'hc, 8'h41);
    wr(4'h8, 8'h01);
    cyc(3);
    check(32'({wake, irq, pin[0]}), 32'h5);
    wr(4'hc, 8'hc1);
    cyc(3);
    check(32'(irq), 32'h0);
    @(posedge core_clk);
    raw <= 2'h0;
    cyc(6);
    check(32'(pin[0]), 32'h0);
    @(posedge core_clk);
    sleep <= 1'b0;
    cyc(0);
    check(32'(irq), 32'h0);
    cyc(8);
    check(32'(irq), 32'h1);
    wr(4'hc, 8'h81);
    cyc(2);
    check(32'({wake, irq}), 32'h0);
  endtask : t_wake

  initial begin
    // a real rising edge at time zero, so the asynchronous reset acts at once
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(4'h0);
    check(d, 32'h0);
    rd(4'h4);
    check(d, 32'h0);
    t_fields();
    check(32'({br, rr}), 32'({cmp_pkg::RESP_OKAY, cmp_pkg::RESP_OKAY}));
    t_polarity();
    t_drive();
    t_change();
    t_wake();
    wr(4'h0, 8'ha0);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    rd(4'h0);
    check(d, 32'h0);
    stop_test();
  end

  // the whole sequence needs about five hundred cycles; the limit allows four thousand
  initial begin
    #200000;
    fails++;
    stop_test();
  end
endmodule : tb_dual_comparator_control
